// *** pkg/tvdac_pkg.sv ***
package tvdac_pkg;
  localparam int unsigned PIX_W = 10;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned WORD_W = 3 * PIX_W + 2;
  // Field positions inside one buffered pixel word
  localparam int unsigned FLD_BLANK = 0;
  localparam int unsigned FLD_SYNC = 1;
  localparam int unsigned FLD_BLUE_LSB = 2;
  localparam int unsigned FLD_GREEN_LSB = FLD_BLUE_LSB + PIX_W;
  localparam int unsigned FLD_RED_LSB = FLD_GREEN_LSB + PIX_W;
  // Pipeline stages from capture edge to converter outputs
  localparam int unsigned PIPE_STAGES = 1;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MAX_PIXEL_RATE_MPS = 150;
  // Values after reset
  localparam logic [PIX_W-1:0] RST_PIX = 10'h000;
  localparam logic RST_PEDESTAL = 1'b0;
  localparam logic RST_SYNC_SRC = 1'b0;
  localparam logic RST_VALID = 1'b0;
  localparam logic RST_READY = 1'b0;
  localparam logic [1:0] RST_SYNC_CHAIN = 2'h0;
endpackage : tvdac_pkg

// *** design/tvdac_fifo.sv ***
module tvdac_fifo #(
  parameter int unsigned WIDTH = tvdac_pkg::WORD_W,
  parameter int unsigned DEPTH = tvdac_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic ready_q;
  logic push;
  logic pop;

  // Ready is registered so the source sees a clean flop output
  assign push = in_valid && ready_q;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + (AW + 1)'(1);
    end else if (pop && !push) begin
      count_d = count_q - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + AW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      ready_q <= tvdac_pkg::RST_READY;
    end else begin
      count_q <= count_d;
      ready_q <= (count_d < DEPTH_C);
    end
  end
endmodule : tvdac_fifo

// *** design/tvdac_input_stage.sv ***
// Contract
// - Red, green and blue 10-bit pixel words are captured on a rising clock edge where pix_valid and pix_ready are both high.
// - A captured low sync control switches the green sync current source off (sync tip).
// - A captured high sync control keeps the green sync current source on.
// - Sync is registered and delayed by the same stages as blanking and pixel words.
// - Sync steers only the green sync current and never touches pixel data or blanking.
// - A captured low blanking control ignores all pixel words and outputs blanking level.
// - While blanked the colour data contribution of all three outputs is zero.
// - Blanking is registered with the same pipeline latency as sync.
// - Captured values reach the converter outputs after one pipeline register stage.
// - Unblanked words ride on a pedestal; blanking disables both data and pedestal.
module tvdac_input_stage (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [tvdac_pkg::PIX_W-1:0] red_pixel_word,
  input wire logic [tvdac_pkg::PIX_W-1:0] green_pixel_word,
  input wire logic [tvdac_pkg::PIX_W-1:0] blue_pixel_word,
  input wire logic sync_n,
  input wire logic blank_n,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic dac_ready,
  output logic out_valid,
  output logic [tvdac_pkg::PIX_W-1:0] red_current_out,
  output logic [tvdac_pkg::PIX_W-1:0] green_current_out,
  output logic [tvdac_pkg::PIX_W-1:0] blue_current_out,
  output logic pedestal_on,
  output logic green_sync_on
);
  localparam int unsigned PW = tvdac_pkg::PIX_W;
  localparam int unsigned WW = tvdac_pkg::WORD_W;

  logic [1:0] rst_chain_q;
  logic rst_sync_n;
  logic [WW-1:0] cap_word;
  logic [WW-1:0] head_word;
  logic head_valid;
  logic fifo_in_ready;
  logic load;
  logic head_blank_n;
  logic head_sync_n;
  logic [PW-1:0] head_red;
  logic [PW-1:0] head_green;
  logic [PW-1:0] head_blue;
  logic [PW-1:0] red_d;
  logic [PW-1:0] green_d;
  logic [PW-1:0] blue_d;
  logic [PW-1:0] red_q;
  logic [PW-1:0] green_q;
  logic [PW-1:0] blue_q;
  logic pedestal_q;
  logic sync_src_q;
  logic valid_q;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_chain_q <= tvdac_pkg::RST_SYNC_CHAIN;
    end else begin
      rst_chain_q <= {rst_chain_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_chain_q[1];

  // Pixel bus shares the pixel clock, so no synchroniser on it
  assign cap_word = {red_pixel_word, green_pixel_word, blue_pixel_word, sync_n, blank_n};

  // The buffer's storage is the capture register itself
  tvdac_fifo #(
    .WIDTH(WW),
    .DEPTH(tvdac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_sync_n),
    .in_valid(pix_valid),
    .in_ready(fifo_in_ready),
    .in_data(cap_word),
    .out_valid(head_valid),
    .out_ready(dac_ready),
    .out_data(head_word)
  );

  assign pix_ready = fifo_in_ready;
  assign load = head_valid && dac_ready;

  assign head_blank_n = head_word[tvdac_pkg::FLD_BLANK];
  assign head_sync_n = head_word[tvdac_pkg::FLD_SYNC];
  assign head_red = head_word[tvdac_pkg::FLD_RED_LSB +: PW];
  assign head_green = head_word[tvdac_pkg::FLD_GREEN_LSB +: PW];
  assign head_blue = head_word[tvdac_pkg::FLD_BLUE_LSB +: PW];

  // Codes pass as unsigned binary; blanking forces the data term to zero
  always_comb begin
    red_d = head_red;
    green_d = head_green;
    blue_d = head_blue;
    if (!head_blank_n) begin
      red_d = '0;
      green_d = '0;
      blue_d = '0;
    end
  end

  // Output stage: one register after the capture edge
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      red_q <= tvdac_pkg::RST_PIX;
      green_q <= tvdac_pkg::RST_PIX;
      blue_q <= tvdac_pkg::RST_PIX;
    end else if (load) begin
      red_q <= red_d;
      green_q <= green_d;
      blue_q <= blue_d;
    end
  end

  // Pedestal follows blanking in the same stage as the data
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pedestal_q <= tvdac_pkg::RST_PEDESTAL;
    end else if (load) begin
      pedestal_q <= head_blank_n;
    end
  end

  // Sync source ignores blanking on purpose; the source keeps sync inside blanking
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_src_q <= tvdac_pkg::RST_SYNC_SRC;
    end else if (load) begin
      sync_src_q <= head_sync_n;
    end
  end

  // Valid pulses for one cycle after each load and drops while the converter stalls
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      valid_q <= tvdac_pkg::RST_VALID;
    end else begin
      valid_q <= load;
    end
  end

  assign red_current_out = red_q;
  assign green_current_out = green_q;
  assign blue_current_out = blue_q;
  assign pedestal_on = pedestal_q;
  assign green_sync_on = sync_src_q;
  assign out_valid = valid_q;

  // Helper: push into an empty buffer while the converter is ready
  logic bypass;
  assign bypass = pix_valid && pix_ready && !head_valid && dac_ready;

  property p_capture_edge;
    @(posedge mclk) disable iff (!rst_sync_n)
    (pix_valid && pix_ready) |=> head_valid;
  endproperty
  a_capture_edge: assert property (p_capture_edge)
    else $error("accepted pixel word not held in buffer");

  property p_sync_tip;
    @(posedge mclk) disable iff (!rst_sync_n)
    (load && !head_sync_n) |=> !green_sync_on;
  endproperty
  a_sync_tip: assert property (p_sync_tip)
    else $error("sync low did not switch green sync source off");

  property p_sync_on;
    @(posedge mclk) disable iff (!rst_sync_n)
    (load && head_sync_n) |=> green_sync_on;
  endproperty
  a_sync_on: assert property (p_sync_on)
    else $error("sync high did not keep green sync source on");

  property p_sync_latency;
    @(posedge mclk) disable iff (!rst_sync_n)
    bypass ##1 dac_ready |=>
      out_valid && (green_sync_on == $past(sync_n, 2));
  endproperty
  a_sync_latency: assert property (p_sync_latency)
    else $error("sync latency differs from one stage");

  property p_sync_no_data_effect;
    @(posedge mclk) disable iff (!rst_sync_n)
    (load && head_blank_n) |=>
      (red_current_out == $past(head_red)) && (green_current_out == $past(head_green))
      && (blue_current_out == $past(head_blue)) && pedestal_on;
  endproperty
  a_sync_no_data_effect: assert property (p_sync_no_data_effect)
    else $error("unblanked data altered");

  property p_blank_zero;
    @(posedge mclk) disable iff (!rst_sync_n)
    (load && !head_blank_n) |=>
      (red_current_out == '0) && (green_current_out == '0) && (blue_current_out == '0);
  endproperty
  a_blank_zero: assert property (p_blank_zero)
    else $error("blanked word left colour data on outputs");

  property p_blank_hold;
    @(posedge mclk) disable iff (!rst_sync_n)
    !pedestal_on |-> (red_current_out | green_current_out | blue_current_out) == '0;
  endproperty
  a_blank_hold: assert property (p_blank_hold)
    else $error("colour data present while blanked");

  property p_blank_latency;
    @(posedge mclk) disable iff (!rst_sync_n)
    bypass ##1 dac_ready |=> out_valid && (pedestal_on == $past(blank_n, 2))
      && (green_sync_on == $past(sync_n, 2));
  endproperty
  a_blank_latency: assert property (p_blank_latency)
    else $error("blank and sync latency differ");

  property p_one_stage;
    @(posedge mclk) disable iff (!rst_sync_n)
    (bypass && blank_n) ##1 dac_ready |=> (red_current_out == $past(red_pixel_word, 2))
      && (green_current_out == $past(green_pixel_word, 2))
      && (blue_current_out == $past(blue_pixel_word, 2));
  endproperty
  a_one_stage: assert property (p_one_stage)
    else $error("pixel did not reach outputs one stage after capture");

  property p_pedestal;
    @(posedge mclk) disable iff (!rst_sync_n)
    load |=> pedestal_on == $past(head_blank_n);
  endproperty
  a_pedestal: assert property (p_pedestal)
    else $error("pedestal does not follow blanking");

  property p_stall_hold;
    @(posedge mclk) disable iff (!rst_sync_n)
    !load |=> $stable(red_current_out) && $stable(pedestal_on) && $stable(green_sync_on);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("outputs changed without a load");

  property p_full_stall;
    @(posedge mclk) disable iff (!rst_sync_n)
    !pix_ready |-> head_valid || !$past(rst_sync_n);
  endproperty
  a_full_stall: assert property (p_full_stall)
    else $error("ready low with empty buffer");

  property p_out_pulse;
    @(posedge mclk) disable iff (!rst_sync_n)
    out_valid == $past(load);
  endproperty
  a_out_pulse: assert property (p_out_pulse)
    else $error("out_valid not a one-cycle answer to a load");

  property p_blank_keeps_sync;
    @(posedge mclk) disable iff (!rst_sync_n)
    (load && !head_blank_n) |=>
      green_sync_on == $past(head_sync_n);
  endproperty
  a_blank_keeps_sync: assert property (p_blank_keeps_sync)
    else $error("blanking altered the green sync source");

  // Reset keeps every output quiet until the synchronised release
  property p_reset_quiet;
    @(posedge mclk)
    !rst_sync_n |-> !out_valid && !pix_ready && !pedestal_on && !green_sync_on
      && ((red_current_out | green_current_out | blue_current_out) == '0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active during reset");

  property p_ready_after_reset;
    @(posedge mclk) disable iff (!rst_sync_n)
    $rose(rst_sync_n) |=> pix_ready && !out_valid;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset)
    else $error("buffer not open one edge after reset release");

  property p_empty_idle;
    @(posedge mclk) disable iff (!rst_sync_n)
    !head_valid |=> !out_valid;
  endproperty
  a_empty_idle: assert property (p_empty_idle)
    else $error("load from an empty buffer");

  // A full buffer stays closed until the converter takes a word
  property p_refuse_hold;
    @(posedge mclk) disable iff (!rst_sync_n)
    (!pix_ready && head_valid && !load) |=> !pix_ready;
  endproperty
  a_refuse_hold: assert property (p_refuse_hold)
    else $error("full buffer reopened without a load");

  c_sync_tip: cover property (@(posedge mclk) disable iff (!rst_sync_n)
    out_valid && !pedestal_on && !green_sync_on);
  c_active_video: cover property (@(posedge mclk) disable iff (!rst_sync_n)
    out_valid && pedestal_on && green_sync_on && (red_current_out == 10'h3FF));
  c_buffer_full: cover property (@(posedge mclk) disable iff (!rst_sync_n)
    pix_valid && !pix_ready);
  c_bypass: cover property (@(posedge mclk) disable iff (!rst_sync_n) bypass ##1 bypass);
  c_sync_low_video: cover property (@(posedge mclk) disable iff (!rst_sync_n)
    out_valid && pedestal_on && !green_sync_on);
endmodule : tvdac_input_stage

// *** sim/tvdac_src_model.sv ***
module tvdac_src_model (
  input wire logic mclk,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [9:0] red,
  output logic [9:0] green,
  output logic [9:0] blue,
  output logic sync_n,
  output logic blank_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_w;
  initial begin
    pix_valid = 1'b0;
    last_w = 32'h00000000;
    {red, green, blue, sync_n, blank_n} = 32'hFFFFFFFF;
  end
  // Word is {red, green, blue, sync_n, blank_n}; held until taken
  task automatic send(input logic [31:0] w, input bit last);
    @(negedge mclk);
    pix_valid = 1'b1;
    last_w = w;
    {red, green, blue, sync_n, blank_n} = w;
    // Ready moves only on rising edges, so its falling-edge value is the one sampled
    while (pix_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    if (last) begin
      @(negedge mclk);
      pix_valid = 1'b0;
      // Released lines show inverse, so a stale capture never matches
      {red, green, blue, sync_n, blank_n} = ~last_w;
    end
  endtask : send
endmodule : tvdac_src_model

// *** sim/tvdac_input_stage_tb_top.sv ***
module tvdac_input_stage_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic dac_ready = 1'b0;
  logic pix_valid, pix_ready, out_valid, pedestal_on, green_sync_on, sync_n, blank_n;
  logic [9:0] red_w, green_w, blue_w, red_o, green_o, blue_o;
  logic [31:0] seen[$];
  int errors = 0;
  int n_compared = 0;
  always #5 mclk = ~mclk;
  tvdac_src_model src (.mclk(mclk), .pix_ready(pix_ready), .pix_valid(pix_valid),
    .red(red_w), .green(green_w), .blue(blue_w), .sync_n(sync_n), .blank_n(blank_n));
  tvdac_input_stage dut (.mclk(mclk), .rst_n(rst_n), .red_pixel_word(red_w),
    .green_pixel_word(green_w), .blue_pixel_word(blue_w), .sync_n(sync_n),
    .blank_n(blank_n), .pix_valid(pix_valid), .pix_ready(pix_ready), .dac_ready(dac_ready),
    .out_valid(out_valid), .red_current_out(red_o), .green_current_out(green_o),
    .blue_current_out(blue_o), .pedestal_on(pedestal_on), .green_sync_on(green_sync_on));
  always @(posedge mclk) begin
    if (out_valid === 1'b1) begin
      seen.push_back({red_o, green_o, blue_o, pedestal_on, green_sync_on});
    end
  end
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // Blanking clears codes and pedestal; sync still steers its source
  function automatic logic [31:0] expect_out(input logic [31:0] w);
    return w[0] ? {w[31:2], 1'b1, w[1]} : {30'h00000000, 1'b0, w[1]};
  endfunction : expect_out
  task automatic results();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic t_reset();
    int k;
    repeat (8) @(negedge mclk);
    check("reset outputs", {red_o, green_o, blue_o, pedestal_on, green_sync_on}, 32'h0);
    check("reset ready", pix_ready, 1'b0);
    rst_n = 1'b1;
    k = 0;
    while (pix_ready !== 1'b1 && k < 10) begin
      @(negedge mclk);
      k++;
    end
    check("ready after reset", pix_ready, 1'b1);
  endtask : t_reset
  task automatic t_single();
    logic [31:0] tab[6];
    tab = '{32'hFFFFFFFF, 32'h00000003, 32'hFFFFFFFD, 32'h556A8006, 32'hFFFFFFFC,
      32'hFFFFFFFE};
    dac_ready = 1'b1;
    foreach (tab[i]) begin
      seen.delete();
      src.send(tab[i], 1'b1);
      @(negedge mclk);
      check("valid after one stage", out_valid, 1'b1);
      check("outputs", {red_o, green_o, blue_o, pedestal_on, green_sync_on},
        expect_out(tab[i]));
      @(negedge mclk);
      check("valid one cycle", out_valid, 1'b0);
      repeat (3) @(negedge mclk);
      check("loads per word", seen.size(), 1);
    end
  endtask : t_single
  task automatic t_fill_drain();
    logic [31:0] w[32];
    logic [9:0] k;
    int n;
    seen.delete();
    dac_ready = 1'b0;
    for (int i = 0; i < 32; i++) begin
      k = i[9:0];
      w[i] = {k, 10'h3FF - k, 10'h2A0 + k, k[0], ~k[1]};
      src.send(w[i], i == 31);
    end
    repeat (3) @(negedge mclk);
    check("ready when full", pix_ready, 1'b0);
    check("held while stalled", seen.size(), 0);
    dac_ready = 1'b1;
    n = 0;
    while (seen.size() < 32 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    repeat (3) @(negedge mclk);
    check("drained count", seen.size(), 32);
    for (int i = 0; i < 32 && i < seen.size(); i++) begin
      check("drained word", seen[i], expect_out(w[i]));
    end
    check("ready after drain", pix_ready, 1'b1);
  endtask : t_fill_drain
  task automatic t_mid_reset();
    int k;
    dac_ready = 1'b0;
    src.send(32'h12345677, 1'b1);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check("mid reset outputs", {red_o, green_o, blue_o, pedestal_on, green_sync_on}, 32'h0);
    check("mid reset flags", {pix_ready, out_valid}, 32'h0);
    rst_n = 1'b1;
    seen.delete();
    dac_ready = 1'b1;
    k = 0;
    while (pix_ready !== 1'b1 && k < 10) begin
      @(negedge mclk);
      k++;
    end
    check("ready after mid reset", pix_ready, 1'b1);
    repeat (3) @(negedge mclk);
    check("buffer cleared by reset", seen.size(), 0);
  endtask : t_mid_reset
  initial begin
    // Run is under 150 cycles (about 1360 ns); 2000-cycle limit is a generous margin
    #20000;
    errors++;
    results();
  end
  initial begin
    t_reset();
    t_single();
    t_fill_drain();
    t_mid_reset();
    results();
  end
endmodule : tvdac_input_stage_tb_top
